// ===== verilog/spfs_pin_select.v
// Contract
// R1 - After reset the three port E lines carry the SPI 0 data-out, data-in and select roles.
// R2 - Bits 5, 6 and 7 of the port E pull-up register each enable one line's pull-up.
// R3 - The master-out data line is an output in master mode and an input in slave mode.
// R4 - A master presents each data-out bit half a clock before the slave's sampling edge.
// R5 - An unselected slave leaves its master-in data line undriven.
// R6 - A selected slave presents each data-in bit half a clock before the master samples.
// R7 - In slave mode the external master asserts select, and the SPI accepts only then.
// R8 - The SPI 1 clock line drives out in master mode and is the clock input in slave mode.
// R9 - The port C line carries the SPI 1 clock only while the phase A alternate bit is set.
// R10 - On the full variant the port C line comes up as the decoder 1 phase A input.
// R11 - In general-purpose role each line's direction is programmed individually.
`timescale 1ns/1ps
`include "spfs_defs.vh"
module spfs_pin_select #(
   parameter FULL_VARIANT = 1
) (
   input wire core_clk,
   input wire rst,
   input wire pe_pullup_wr,
   input wire [`SPFS_PU_W-1:0] pe_pullup_wdata,
   output reg [`SPFS_PU_W-1:0] port_e_pullup_reg,
   input wire pe_fsel_wr,
   input wire [`SPFS_E_W-1:0] pe_fsel_wdata,
   input wire pe_dir_wr,
   input wire [`SPFS_E_W-1:0] pe_dir_wdata,
   input wire pe_dout_wr,
   input wire [`SPFS_E_W-1:0] pe_dout_wdata,
   output reg [`SPFS_E_W-1:0] pe_din,
   input wire pc0_cfg_wr,
   input wire [`SPFS_C_W-1:0] pc0_cfg_wdata,
   output reg pc0_din,
   input wire sysint_wr,
   input wire [`SPFS_SYS_W-1:0] sysint_wdata,
   output reg [`SPFS_SYS_W-1:0] sysint_pin_select_reg,
   input wire spi0_master,
   input wire spi0_drive_en,
   input wire spi0_mosi_tx,
   input wire spi0_miso_tx,
   output reg spi0_mosi_rx,
   output reg spi0_miso_rx,
   output reg spi0_ss_n_rx,
   input wire spi1_master,
   input wire spi1_sclk_tx,
   output reg spi1_sclk_rx,
   output reg decoder1_phase_a_in,
   input wire port_e_line_5_in,
   output reg port_e_line_5_out,
   output reg port_e_line_5_oe,
   output wire port_e_line_5_pu,
   input wire port_e_line_6_in,
   output reg port_e_line_6_out,
   output reg port_e_line_6_oe,
   output wire port_e_line_6_pu,
   input wire port_e_line_7_in,
   output reg port_e_line_7_out,
   output reg port_e_line_7_oe,
   output wire port_e_line_7_pu,
   input wire port_c_line_0_in,
   output reg port_c_line_0_out,
   output reg port_c_line_0_oe
);

   // Variant-dependent reset of the port C general-purpose select
   localparam [0:0] PC_GPIO_RST = (FULL_VARIANT != 0) ? 1'h0 : 1'h1;

   reg [`SPFS_E_W-1:0] pe_fsel_r;
   reg [`SPFS_E_W-1:0] pe_dir_r;
   reg [`SPFS_E_W-1:0] pe_dout_r;
   reg pc_gpio_r;
   reg pc_dir_r;
   reg pc_dout_r;
   reg [`SPFS_SYN_W-1:0] syn1_r;
   reg [`SPFS_SYN_W-1:0] syn2_r;
   reg [`SPFS_SYN_W-1:0] syn3_r;
   reg [`SPFS_SYN_W-1:0] filt_r;
   reg [`SPFS_SYN_W-1:0] filt_nxt;
   reg mosi_hold_r;
   reg miso_hold_r;
   reg e5_out_nxt;
   reg e5_oe_nxt;
   reg e6_out_nxt;
   reg e6_oe_nxt;
   reg e7_out_nxt;
   reg e7_oe_nxt;
   reg c0_out_nxt;
   reg c0_oe_nxt;
   wire slave_sel;
   wire pc_sclk_role;

   // Software-written configuration; port E serial roles win after reset
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         port_e_pullup_reg <= `SPFS_PU_RST;
         pe_fsel_r <= `SPFS_E_FSEL_RST; // R1
         pe_dir_r <= `SPFS_E_DIR_RST;
         pe_dout_r <= `SPFS_E_DOUT_RST;
         pc_gpio_r <= PC_GPIO_RST; // R10
         pc_dir_r <= 1'h0;
         pc_dout_r <= 1'h0;
         sysint_pin_select_reg <= `SPFS_SYS_RST;
      end else begin
         if (pe_pullup_wr) begin
            port_e_pullup_reg <= pe_pullup_wdata; // R2
         end
         if (pe_fsel_wr) begin
            pe_fsel_r <= pe_fsel_wdata;
         end
         if (pe_dir_wr) begin
            pe_dir_r <= pe_dir_wdata; // R11
         end
         if (pe_dout_wr) begin
            pe_dout_r <= pe_dout_wdata;
         end
         if (pc0_cfg_wr) begin
            pc_gpio_r <= pc0_cfg_wdata[`SPFS_C_GPIO];
            pc_dir_r <= pc0_cfg_wdata[`SPFS_C_DIR]; // R11
            pc_dout_r <= pc0_cfg_wdata[`SPFS_C_DOUT];
         end
         if (sysint_wr) begin
            sysint_pin_select_reg <= sysint_wdata;
         end
      end
   end

   // Pull-up enables follow their own bits; cleared bit means no pull-up
   assign port_e_line_5_pu = port_e_pullup_reg[`SPFS_PU_MOSI]; // R2
   assign port_e_line_6_pu = port_e_pullup_reg[`SPFS_PU_MISO]; // R2
   assign port_e_line_7_pu = port_e_pullup_reg[`SPFS_PU_SS]; // R2

   // Three-stage synchroniser; the first stage feeds only the second
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         syn1_r <= {`SPFS_SYN_W{1'h1}};
         syn2_r <= {`SPFS_SYN_W{1'h1}};
         syn3_r <= {`SPFS_SYN_W{1'h1}};
         filt_r <= {`SPFS_SYN_W{1'h1}};
      end else begin
         syn1_r <= {port_c_line_0_in, port_e_line_7_in, port_e_line_6_in, port_e_line_5_in};
         syn2_r <= syn1_r;
         syn3_r <= syn2_r;
         filt_r <= filt_nxt;
      end
   end

   // A bit moves only once stages two and three agree, masking one-cycle glitches
   always @* begin
      filt_nxt = (syn2_r & syn3_r) | (filt_r & (syn2_r ^ syn3_r));
   end

   // Select is active low; slave is addressed only while it is held low
   assign slave_sel = !spi0_master && !pe_fsel_r[`SPFS_E_SS] &&
                      !filt_r[`SPFS_E_SS]; // R7
   assign pc_sclk_role = !pc_gpio_r && sysint_pin_select_reg[`SPFS_SYS_PA_ALT]; // R9

   // Outgoing serial bits change only on the core's drive edge, which sits
   // half a serial clock ahead of the far side's sampling edge
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mosi_hold_r <= 1'h0;
         miso_hold_r <= 1'h0;
      end else begin
         if (spi0_drive_en && spi0_master) begin
            mosi_hold_r <= spi0_mosi_tx; // R4
         end
         if (spi0_drive_en && slave_sel) begin
            miso_hold_r <= spi0_miso_tx; // R6
         end
      end
   end

   // Port E pad drive: serial role or general-purpose role per line
   always @* begin
      if (pe_fsel_r[`SPFS_E_MOSI]) begin
         e5_out_nxt = pe_dout_r[`SPFS_E_MOSI];
         e5_oe_nxt = pe_dir_r[`SPFS_E_MOSI]; // R11
      end else begin
         e5_out_nxt = mosi_hold_r;
         e5_oe_nxt = spi0_master; // R3
      end
      if (pe_fsel_r[`SPFS_E_MISO]) begin
         e6_out_nxt = pe_dout_r[`SPFS_E_MISO];
         e6_oe_nxt = pe_dir_r[`SPFS_E_MISO]; // R11
      end else begin
         // Master listens; unselected slave floats so other slaves can share the line
         e6_out_nxt = miso_hold_r;
         e6_oe_nxt = slave_sel; // R5
      end
      if (pe_fsel_r[`SPFS_E_SS]) begin
         e7_out_nxt = pe_dout_r[`SPFS_E_SS];
         e7_oe_nxt = pe_dir_r[`SPFS_E_SS]; // R11
      end else begin
         e7_out_nxt = 1'h0;
         e7_oe_nxt = 1'h0;
      end
   end

   // Port C line 0 drive: general-purpose, SPI 1 clock, or decoder input
   always @* begin
      if (pc_gpio_r) begin
         c0_out_nxt = pc_dout_r;
         c0_oe_nxt = pc_dir_r; // R11
      end else if (pc_sclk_role) begin
         c0_out_nxt = spi1_sclk_tx;
         c0_oe_nxt = spi1_master; // R8
      end else begin
         c0_out_nxt = 1'h0;
         c0_oe_nxt = 1'h0; // R10
      end
   end

   // Registered pad outputs; one cycle of latency keeps pads glitch-free
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         port_e_line_5_out <= 1'h0;
         port_e_line_5_oe <= 1'h0;
         port_e_line_6_out <= 1'h0;
         port_e_line_6_oe <= 1'h0;
         port_e_line_7_out <= 1'h0;
         port_e_line_7_oe <= 1'h0;
         port_c_line_0_out <= 1'h0;
         port_c_line_0_oe <= 1'h0;
      end else begin
         port_e_line_5_out <= e5_out_nxt;
         port_e_line_5_oe <= e5_oe_nxt;
         port_e_line_6_out <= e6_out_nxt;
         port_e_line_6_oe <= e6_oe_nxt;
         port_e_line_7_out <= e7_out_nxt;
         port_e_line_7_oe <= e7_oe_nxt;
         port_c_line_0_out <= c0_out_nxt;
         port_c_line_0_oe <= c0_oe_nxt;
      end
   end

   // Core-side receive values; roles that are off read as idle levels
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         spi0_mosi_rx <= 1'h0;
         spi0_miso_rx <= 1'h0;
         spi0_ss_n_rx <= 1'h1;
         spi1_sclk_rx <= 1'h0;
         decoder1_phase_a_in <= 1'h0;
         pe_din <= {`SPFS_E_W{1'h0}};
         pc0_din <= 1'h0;
      end else begin
         // Slave takes data-out from the pin; master ignores it
         spi0_mosi_rx <= (!spi0_master && !pe_fsel_r[`SPFS_E_MOSI]) ?
                         filt_r[`SPFS_E_MOSI] : 1'h0; // R3
         spi0_miso_rx <= (spi0_master && !pe_fsel_r[`SPFS_E_MISO]) ?
                         filt_r[`SPFS_E_MISO] : 1'h0;
         spi0_ss_n_rx <= !slave_sel; // R7
         spi1_sclk_rx <= (pc_sclk_role && !spi1_master) ?
                         filt_r[`SPFS_SYN_C0] : 1'h0; // R8
         decoder1_phase_a_in <= (!pc_gpio_r && !pc_sclk_role) ?
                                filt_r[`SPFS_SYN_C0] : 1'h0; // R10
         pe_din <= filt_r[`SPFS_E_W-1:0];
         pc0_din <= filt_r[`SPFS_SYN_C0];
      end
   end

endmodule // spfs_pin_select

// ===== verilog/spfs_defs.vh
`ifndef SPFS_DEFS_VH
`define SPFS_DEFS_VH
// Port E pull-up register: width, reset value and pin bit positions
`define SPFS_PU_W 8
`define SPFS_PU_RST 8'hFF
`define SPFS_PU_MOSI 5
`define SPFS_PU_MISO 6
`define SPFS_PU_SS 7
// Port E line index inside the three-bit function/direction/data fields
`define SPFS_E_MOSI 0
`define SPFS_E_MISO 1
`define SPFS_E_SS 2
`define SPFS_E_W 3
// Port E function select reset: all lines on the serial peripheral
`define SPFS_E_FSEL_RST 3'h0
`define SPFS_E_DIR_RST 3'h0
`define SPFS_E_DOUT_RST 3'h0
// Port C line 0 configuration word fields
`define SPFS_C_GPIO 0
`define SPFS_C_DIR 1
`define SPFS_C_DOUT 2
`define SPFS_C_W 3
// System integration pin-select register
`define SPFS_SYS_W 8
`define SPFS_SYS_RST 8'h00
`define SPFS_SYS_PA_ALT 0
// Synchroniser input vector: E5, E6, E7, C0
`define SPFS_SYN_W 4
`define SPFS_SYN_C0 3
`endif

// ===== sim/spfs_ext_spi.sv
`timescale 1ns/1ps
// Far-side SPI device; resolves each pad from all drivers
module spfs_ext_spi (
   input logic core_clk,
   input logic ext_master,
   input logic [3:0] ext_drv,
   input logic [3:0] oe,
   input logic [3:0] dout,
   input logic [2:0] pu,
   output logic [3:0] pad
);
   logic tg = 1'h0;
   // A floating line toggles so a stale level never reads as valid
   always @(posedge core_clk) tg <= ~tg;
   // Order: mosi, miso, select, phase; pull-up wins on undriven lines
   always_comb begin
      pad[0] = oe[0] ? dout[0] : ext_master ? ext_drv[0] : pu[0] | tg;
      pad[1] = oe[1] ? dout[1] : !ext_master ? ext_drv[1] : pu[1] | tg;
      pad[2] = oe[2] ? dout[2] : ext_master ? ext_drv[2] : pu[2] | tg;
      pad[3] = oe[3] ? dout[3] : ext_drv[3];
   end
endmodule // spfs_ext_spi

// ===== sim/spfs_pin_select_monitor.sv
`timescale 1ns/1ps
// Pad and role checks at the pin-select ports
module spfs_pin_select_monitor (
   input logic core_clk,
   input logic rst,
   input logic pe_fsel_wr,
   input logic [2:0] pe_fsel_wdata,
   input logic pc0_cfg_wr,
   input logic [2:0] pc0_cfg_wdata,
   input logic [7:0] port_e_pullup_reg,
   input logic [7:0] sysint_pin_select_reg,
   input logic spi0_master,
   input logic spi0_drive_en,
   input logic spi0_mosi_tx,
   input logic spi0_ss_n_rx,
   input logic spi1_master,
   input logic spi1_sclk_tx,
   input logic port_e_line_5_out,
   input logic port_e_line_5_oe,
   input logic port_e_line_6_oe,
   input logic port_e_line_7_oe,
   input logic port_e_line_5_pu,
   input logic port_e_line_6_pu,
   input logic port_e_line_7_pu,
   input logic port_c_line_0_out,
   input logic port_c_line_0_oe
);
   logic [2:0] fs_r;
   logic pcg_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Shadow of the role selects; pads lag it by one cycle
   // Port C general-purpose shadow resets as the full variant does
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fs_r <= 3'h0;
         pcg_r <= 1'h0;
      end else begin
         if (pe_fsel_wr) fs_r <= pe_fsel_wdata;
         if (pc0_cfg_wr) pcg_r <= pc0_cfg_wdata[0];
      end
   end
   chk_pull_up_map: assert property (
      {port_e_line_7_pu, port_e_line_6_pu, port_e_line_5_pu} == port_e_pullup_reg[7:5])
      else $error("pull-up map");
   chk_mosi_dir: assert property (
      !$past(rst) && !$past(fs_r[0]) |-> port_e_line_5_oe == $past(spi0_master))
      else $error("mosi direction");
   chk_miso_unsel_hiz: assert property (
      !$past(rst) && !$past(spi0_master) && $past(fs_r[2:1]) == 2'h0
      |-> port_e_line_6_oe == !spi0_ss_n_rx) else $error("miso drive");
   chk_ss_input_only: assert property (
      !$past(fs_r[2]) |-> !port_e_line_7_oe) else $error("select driven");
   chk_mosi_launch: assert property (
      spi0_drive_en && spi0_master && !fs_r[0]
      |-> ##2 port_e_line_5_out == $past(spi0_mosi_tx, 2)) else $error("mosi launch");
   chk_mosi_hold: assert property (
      (!spi0_drive_en && !fs_r[0])[*2] |=> $stable(port_e_line_5_out))
      else $error("mosi moved");
   chk_sclk1_master: assert property (
      $past(sysint_pin_select_reg[0] && spi1_master && !pcg_r)
      |-> port_c_line_0_oe && port_c_line_0_out == $past(spi1_sclk_tx))
      else $error("sclk1 out");
   chk_sclk1_gate: assert property (
      !$past(sysint_pin_select_reg[0]) && !$past(pcg_r) |-> !port_c_line_0_oe)
      else $error("sclk1 gate");
   cover property (spi0_drive_en && spi0_master);
   cover property (port_e_line_6_oe);
   cover property (port_c_line_0_oe);
endmodule // spfs_pin_select_monitor

// ===== sim/test_spi_pin_function_select.sv
`timescale 1ns/1ps
// Pin-select bench: one port of strobes, far-side device on the pads
module test_spi_pin_function_select;
   logic core_clk = 1'h0, rst = 1'h1, pe_pullup_wr = 1'h0, pe_fsel_wr = 1'h0, pe_dir_wr = 1'h0;
   logic pe_dout_wr = 1'h0, pc0_cfg_wr = 1'h0, sysint_wr = 1'h0, spi0_master = 1'h0;
   logic spi0_drive_en = 1'h0, spi0_mosi_tx = 1'h0, spi0_miso_tx = 1'h0, spi1_master = 1'h0;
   logic spi1_sclk_tx = 1'h0, ext_master = 1'h0, pc0_din, spi0_mosi_rx, spi0_miso_rx;
   logic [7:0] pe_pullup_wdata = 8'h00, sysint_wdata = 8'h00, port_e_pullup_reg;
   logic [7:0] sysint_pin_select_reg;
   logic [2:0] pe_fsel_wdata = 3'h0, pe_dir_wdata = 3'h0, pe_dout_wdata = 3'h0;
   logic [2:0] pc0_cfg_wdata = 3'h0, pe_din;
   logic [3:0] ext_drv = 4'hE;
   logic spi0_ss_n_rx, spi1_sclk_rx, decoder1_phase_a_in, port_c_line_0_in;
   logic port_e_line_5_in, port_e_line_5_out, port_e_line_5_oe, port_e_line_5_pu;
   logic port_e_line_6_in, port_e_line_6_out, port_e_line_6_oe, port_e_line_6_pu;
   logic port_e_line_7_in, port_e_line_7_out, port_e_line_7_oe, port_e_line_7_pu;
   logic port_c_line_0_out, port_c_line_0_oe;
   int fail_count = 0, checks = 0;
   spfs_pin_select spfs_pin_select_i (.*);
   spfs_ext_spi spfs_ext_spi_i (.core_clk(core_clk), .ext_master(ext_master), .ext_drv(ext_drv),
      .oe({port_c_line_0_oe, port_e_line_7_oe, port_e_line_6_oe, port_e_line_5_oe}),
      .dout({port_c_line_0_out, port_e_line_7_out, port_e_line_6_out, port_e_line_5_out}),
      .pu({port_e_line_7_pu, port_e_line_6_pu, port_e_line_5_pu}),
      .pad({port_c_line_0_in, port_e_line_7_in, port_e_line_6_in, port_e_line_5_in}));
   // 50 ns period
   always #25 core_clk = ~core_clk;
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Sample 1 ns after the edge so flop updates have landed
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // One-cycle strobe; sel 0 pull-up, 1 role, 2 direction, 3 data, 4 sysint, 5 port C
   task wr(input int sel, input logic [7:0] d);
      @(posedge core_clk);
      {pe_pullup_wdata, sysint_wdata} <= {d, d};
      {pe_fsel_wdata, pe_dir_wdata, pe_dout_wdata, pc0_cfg_wdata} <= {4{d[2:0]}};
      {pe_pullup_wr, pe_fsel_wr, pe_dir_wr, pe_dout_wr, sysint_wr, pc0_cfg_wr} <= 6'h20 >> sel;
      @(posedge core_clk);
      {pe_pullup_wr, pe_fsel_wr, pe_dir_wr, pe_dout_wr, sysint_wr, pc0_cfg_wr} <= 6'h00;
      #1;
   endtask
   // SPI core drive pulse carrying both data bits
   task drv(input logic m, input logic s);
      @(posedge core_clk);
      {spi0_drive_en, spi0_mosi_tx, spi0_miso_tx} <= {1'h1, m, s};
      @(posedge core_clk);
      spi0_drive_en <= 1'h0;
      tick(2);
   endtask
   task end_sim;
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      #100000;
      fail_count++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge core_clk);
      chk({port_e_pullup_reg, port_e_line_7_pu, port_e_line_6_pu, port_e_line_5_pu}, 16'h7FF);
      rst <= 1'h0;
      tick(6);
      chk({port_e_line_5_oe, port_e_line_7_oe, spi0_ss_n_rx}, 16'h1);
      chk({port_c_line_0_oe, decoder1_phase_a_in}, 16'h1);
      wr(0, 8'hA0);
      chk({port_e_pullup_reg, port_e_line_7_pu, port_e_line_6_pu, port_e_line_5_pu}, 16'h505);
      spi0_master <= 1'h1;
      drv(1'h1, 1'h0);
      chk({port_e_line_5_oe, port_e_line_5_out, port_e_line_6_oe}, 16'h6);
      drv(1'h0, 1'h0);
      chk(port_e_line_5_out, 16'h0);
      chk(spi0_miso_rx, 16'h1);
      {spi1_master, spi1_sclk_tx, ext_drv[3]} <= 3'h6;
      wr(4, 8'h01);
      tick(1);
      chk({sysint_pin_select_reg, port_c_line_0_oe, port_c_line_0_out}, 16'h7);
      {spi1_master, ext_drv[3]} <= 2'h1;
      tick(6);
      chk({port_c_line_0_oe, spi1_sclk_rx}, 16'h1);
      ext_drv[3] <= 1'h1;
      wr(4, 8'h00);
      tick(6);
      chk({port_c_line_0_oe, decoder1_phase_a_in}, 16'h1);
      {spi0_master, ext_master, ext_drv[0]} <= 3'h3;
      tick(6);
      chk({port_e_line_5_oe, spi0_mosi_rx, spi0_ss_n_rx, port_e_line_6_oe}, 16'h6);
      ext_drv[2] <= 1'h0;
      tick(6);
      chk({spi0_ss_n_rx, port_e_line_6_oe}, 16'h1);
      drv(1'h0, 1'h1);
      chk(port_e_line_6_out, 16'h1);
      ext_master <= 1'h0;
      wr(1, 8'h07);
      wr(2, 8'h05);
      wr(3, 8'h06);
      tick(6);
      chk({port_e_line_7_oe, port_e_line_6_oe, port_e_line_5_oe, pe_din[1]}, 16'hB);
      chk({port_e_line_7_out, port_e_line_5_out}, 16'h2);
      // Port C line in general-purpose role: output first, then input
      wr(5, 8'h07);
      tick(1);
      chk({port_c_line_0_oe, port_c_line_0_out, decoder1_phase_a_in}, 16'h6);
      ext_drv[3] <= 1'h0;
      wr(5, 8'h01);
      tick(7);
      chk({port_c_line_0_oe, pc0_din}, 16'h0);
      end_sim;
   end
endmodule // test_spi_pin_function_select
bind spfs_pin_select spfs_pin_select_monitor spfs_pin_select_monitor_i (.*);
